//--- design/ulcdu_pkg.sv
// constants and types for the unsigned long compare and divide unit
//
// Notes on behaviour
// (RULE1) register compare reads one register byte, compares unsigned, changes no register
// (RULE2) compare sets bit 1 when first is smaller, bit 0 when equal, else clears both
// (RULE3) operand of other width is converted to working width, 32 or 64 bits, first
// (RULE4) immediate compare widens the next byte, compares with working register, sets flags
// (RULE5) register-zero compare uses register 0 when 32-bit, register 128 when 64-bit
// (RULE6) two-register compare reads two numbers and compares first with second, unsigned
// (RULE7) status byte from these instructions is visible to the host as status
// (RULE8) register divide: quotient to working register, remainder to register 0 or 128
// (RULE9) zero divisor gives an all-ones quotient of the working width
// (RULE10) immediate divide widens the byte, stores quotient and remainder, status from quotient
// (RULE11) register-zero divide uses register 0 or 128 and overwrites it with remainder
// (RULE12) long write reads register number then four bytes msb first, stores, sets status
// (RULE13) long write into a 64-bit register converts the 32-bit value to 64 bits
// (RULE14) registers 0 to 127 are 32-bit, registers 128 to 255 are 64-bit
// (RULE15) host sends exactly the operand bytes each opcode needs, right after it
package ulcdu_pkg;

	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_UCMP_REG = 8'hA3;
	localparam logic [7:0] OP_UCMP_IMM = 8'hB5;
	localparam logic [7:0] OP_UCMP_ZERO = 8'hAC;
	localparam logic [7:0] OP_UCMP_TWO = 8'hBA;
	localparam logic [7:0] OP_UDIV_REG = 8'hA2;
	localparam logic [7:0] OP_UDIV_IMM = 8'hB4;
	localparam logic [7:0] OP_UDIV_ZERO = 8'hAB;
	localparam logic [7:0] OP_LONG_WRITE_REGISTER = 8'h90;

	// ----------------------------------------
	// registers and status
	// ----------------------------------------
	localparam logic [7:0] REG_ZERO_32 = 8'h00;
	localparam logic [7:0] REG_ZERO_64 = 8'h80;
	localparam int STAT_LESS_BIT = 1;
	localparam int STAT_EQUAL_BIT = 0;
	localparam int STAT_SIGN_BIT = 1;
	localparam int STAT_ZERO_BIT = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [63:0] ALL_ONES_64 = 64'hFFFFFFFFFFFFFFFF;
	localparam logic [63:0] ALL_ONES_32 = 64'h00000000FFFFFFFF;
	localparam logic [6:0] DIV_STEPS = 7'h40;
	localparam logic [2:0] MAX_ARGS = 3'h5;

	typedef logic [63:0] ulcdu_word_t;

	// decoded instruction carried from the collector to execution
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] arg0;
		logic [7:0] arg1;
		logic [31:0] value;
	} ulcdu_cmd_s;

endpackage

//--- design/ulcdu_unit.sv
// unsigned long compare, unsigned divide and long write execution unit
`timescale 1ns/1ps
module ulcdu_unit
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_data_in,
	output logic byte_ready_out,
	input wire logic [7:0] sel_a_in,
	input wire logic [7:0] peek_reg_in,
	output logic [63:0] peek_data_out,
	output logic [7:0] status_out,
	output logic busy_out
);

	// ----------------------------------------
	// state and storage
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		ST_OPCODE = 3'b000,
		ST_ARGS = 3'b001,
		ST_EXEC = 3'b010,
		ST_DIV = 3'b011,
		ST_DIV_WB = 3'b100
	} ulcdu_state_e;

	ulcdu_state_e state_r;
	ulcdu_pkg::ulcdu_cmd_s cmd_r;
	logic [2:0] arg_cnt_r;
	logic [2:0] arg_need_r;
	logic [7:0] status_r;
	logic [31:0] regs32_r [0:127];
	logic [63:0] regs64_r [0:127];
	logic [64:0] rem_r;
	logic [63:0] quo_r;
	logic [63:0] dvsr_r;
	logic [6:0] step_r;
	logic div_w64_r;
	logic [7:0] rem_dst_r;
	logic [63:0] peek_r;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [2:0] arg_count(input logic [7:0] op);
		case (op)
			ulcdu_pkg::OP_UCMP_REG: arg_count = 3'h1;
			ulcdu_pkg::OP_UCMP_IMM: arg_count = 3'h1;
			ulcdu_pkg::OP_UCMP_TWO: arg_count = 3'h2;
			ulcdu_pkg::OP_UDIV_REG: arg_count = 3'h1;
			ulcdu_pkg::OP_UDIV_IMM: arg_count = 3'h1;
			ulcdu_pkg::OP_LONG_WRITE_REGISTER: arg_count = ulcdu_pkg::MAX_ARGS;
			default: arg_count = 3'h0;
		endcase
	endfunction

	// native value of a register, 32-bit ones sign-extended to 64
	function automatic ulcdu_pkg::ulcdu_word_t read_reg(input logic [7:0] idx);
		logic [31:0] v32;
		v32 = regs32_r[idx[6:0]];
		if (idx[7]) // [RULE14]
		begin
			read_reg = regs64_r[idx[6:0]];
		end
		else
		begin
			read_reg = {{32{v32[31]}}, v32};
		end
	endfunction

	// fit a value to the working width
	function automatic ulcdu_pkg::ulcdu_word_t fit(input ulcdu_pkg::ulcdu_word_t v,
		input logic w64);
		fit = w64 ? v : {32'h00000000, v[31:0]}; // [RULE3]
	endfunction

	function automatic logic [7:0] cmp_status(input ulcdu_pkg::ulcdu_word_t x,
		input ulcdu_pkg::ulcdu_word_t y);
		cmp_status = 8'h00;
		cmp_status[ulcdu_pkg::STAT_LESS_BIT] = (x < y); // [RULE2]
		cmp_status[ulcdu_pkg::STAT_EQUAL_BIT] = (x == y); // [RULE2]
	endfunction

	function automatic logic [7:0] long_status(input ulcdu_pkg::ulcdu_word_t v,
		input logic w64);
		long_status = 8'h00;
		long_status[ulcdu_pkg::STAT_SIGN_BIT] = w64 ? v[63] : v[31];
		long_status[ulcdu_pkg::STAT_ZERO_BIT] = w64 ? (v == 64'h0) : (v[31:0] == 32'h0);
	endfunction

	// ----------------------------------------
	// execution operands
	// ----------------------------------------
	logic a_w64;
	logic cmp_w64;
	logic [7:0] zero_reg;
	ulcdu_pkg::ulcdu_word_t a_val;
	ulcdu_pkg::ulcdu_word_t cmp_x;
	ulcdu_pkg::ulcdu_word_t cmp_y;
	ulcdu_pkg::ulcdu_word_t div_y;
	ulcdu_pkg::ulcdu_word_t wr_val;
	logic is_cmp;
	logic is_div;
	logic [64:0] rem_shift;
	logic [64:0] rem_sub;

	always_comb
	begin
		a_w64 = sel_a_in[7];
		zero_reg = a_w64 ? ulcdu_pkg::REG_ZERO_64 : ulcdu_pkg::REG_ZERO_32; // [RULE5] [RULE11]
		a_val = fit(read_reg(sel_a_in), a_w64);
		cmp_w64 = a_w64;
		cmp_x = a_val;
		cmp_y = 64'h0;
		div_y = 64'h0;
		is_cmp = 1'b0;
		is_div = 1'b0;
		case (cmd_r.op)
			ulcdu_pkg::OP_UCMP_REG:
			begin
				is_cmp = 1'b1;
				cmp_y = fit(read_reg(cmd_r.arg0), a_w64); // [RULE1] [RULE3]
			end
			ulcdu_pkg::OP_UCMP_IMM:
			begin
				is_cmp = 1'b1;
				cmp_y = {56'h0, cmd_r.arg0}; // [RULE4]
			end
			ulcdu_pkg::OP_UCMP_ZERO:
			begin
				is_cmp = 1'b1;
				cmp_y = fit(read_reg(zero_reg), a_w64); // [RULE5]
			end
			ulcdu_pkg::OP_UCMP_TWO:
			begin
				is_cmp = 1'b1;
				cmp_w64 = cmd_r.arg0[7];
				cmp_x = fit(read_reg(cmd_r.arg0), cmd_r.arg0[7]); // [RULE6]
				cmp_y = fit(read_reg(cmd_r.arg1), cmd_r.arg0[7]); // [RULE6] [RULE3]
			end
			ulcdu_pkg::OP_UDIV_REG:
			begin
				is_div = 1'b1;
				div_y = fit(read_reg(cmd_r.arg0), a_w64); // [RULE8] [RULE3]
			end
			ulcdu_pkg::OP_UDIV_IMM:
			begin
				is_div = 1'b1;
				div_y = {56'h0, cmd_r.arg0}; // [RULE10]
			end
			ulcdu_pkg::OP_UDIV_ZERO:
			begin
				is_div = 1'b1;
				div_y = fit(read_reg(zero_reg), a_w64); // [RULE11]
			end
			default:
			begin
				is_cmp = 1'b0;
			end
		endcase
		if (cmd_r.arg0[7]) // [RULE13]
		begin
			wr_val = {{32{cmd_r.value[31]}}, cmd_r.value};
		end
		else
		begin
			wr_val = {32'h00000000, cmd_r.value};
		end
		rem_shift = {rem_r[63:0], quo_r[63]};
		rem_sub = rem_shift - {1'b0, dvsr_r};
	end

	// ----------------------------------------
	// sequencer: opcode, operand bytes, execution
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state_r <= ST_OPCODE;
			cmd_r <= '0;
			arg_cnt_r <= 3'h0;
			arg_need_r <= 3'h0;
		end
		else
		begin
			case (state_r)
				ST_OPCODE:
				begin
					if (byte_valid_in)
					begin
						cmd_r <= '0;
						cmd_r.op <= byte_data_in;
						arg_cnt_r <= 3'h0;
						arg_need_r <= arg_count(byte_data_in); // [RULE15]
						state_r <= (arg_count(byte_data_in) == 3'h0) ? ST_EXEC : ST_ARGS;
					end
				end
				ST_ARGS:
				begin
					if (byte_valid_in)
					begin
						if (arg_cnt_r == 3'h0)
						begin
							cmd_r.arg0 <= byte_data_in;
						end
						else if (arg_cnt_r == 3'h1 && cmd_r.op == ulcdu_pkg::OP_UCMP_TWO)
						begin
							cmd_r.arg1 <= byte_data_in;
						end
						else
						begin
							cmd_r.value <= {cmd_r.value[23:0], byte_data_in}; // [RULE12]
						end
						arg_cnt_r <= arg_cnt_r + 3'h1;
						if (arg_cnt_r + 3'h1 == arg_need_r)
						begin
							state_r <= ST_EXEC;
						end
					end
				end
				ST_EXEC:
				begin
					state_r <= is_div ? ST_DIV : ST_OPCODE;
				end
				ST_DIV:
				begin
					if (step_r == ulcdu_pkg::DIV_STEPS - 7'h1)
					begin
						state_r <= ST_DIV_WB;
					end
				end
				ST_DIV_WB:
				begin
					state_r <= ST_OPCODE;
				end
				default:
				begin
					state_r <= ST_OPCODE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// restoring divider, one quotient bit per clock
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			rem_r <= '0;
			quo_r <= '0;
			dvsr_r <= '0;
			step_r <= 7'h0;
			div_w64_r <= 1'b0;
			rem_dst_r <= 8'h00;
		end
		else if (state_r == ST_EXEC && is_div)
		begin
			rem_r <= '0;
			quo_r <= a_val;
			dvsr_r <= div_y;
			step_r <= 7'h0;
			div_w64_r <= a_w64;
			rem_dst_r <= zero_reg; // [RULE8] [RULE10] [RULE11]
		end
		else if (state_r == ST_DIV)
		begin
			step_r <= step_r + 7'h1;
			if (!rem_sub[64])
			begin
				rem_r <= rem_sub;
				quo_r <= {quo_r[62:0], 1'b1};
			end
			else
			begin
				rem_r <= rem_shift;
				quo_r <= {quo_r[62:0], 1'b0};
			end
		end
	end

	// quotient with the zero-divisor case forced to all ones
	ulcdu_pkg::ulcdu_word_t quo_final;
	assign quo_final = (dvsr_r == 64'h0) ?
		(div_w64_r ? ulcdu_pkg::ALL_ONES_64 : ulcdu_pkg::ALL_ONES_32) : quo_r; // [RULE9]

	// ----------------------------------------
	// register file writes
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (state_r == ST_EXEC && cmd_r.op == ulcdu_pkg::OP_LONG_WRITE_REGISTER)
		begin
			if (cmd_r.arg0[7]) // [RULE12] [RULE13]
			begin
				regs64_r[cmd_r.arg0[6:0]] <= wr_val;
			end
			else
			begin
				regs32_r[cmd_r.arg0[6:0]] <= wr_val[31:0];
			end
		end
		else if (state_r == ST_DIV_WB)
		begin
			// remainder first, so a working register 0 or 128 keeps the quotient
			if (rem_dst_r[7])
			begin
				regs64_r[rem_dst_r[6:0]] <= rem_r[63:0]; // [RULE8] [RULE11]
			end
			else
			begin
				regs32_r[rem_dst_r[6:0]] <= rem_r[31:0];
			end
			if (div_w64_r)
			begin
				regs64_r[sel_a_in[6:0]] <= quo_final; // [RULE8]
			end
			else
			begin
				regs32_r[sel_a_in[6:0]] <= quo_final[31:0];
			end
		end
	end

	// ----------------------------------------
	// status byte
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			status_r <= ulcdu_pkg::STATUS_RESET;
		end
		else if (state_r == ST_EXEC && is_cmp)
		begin
			status_r <= cmp_status(fit(cmp_x, cmp_w64), fit(cmp_y, cmp_w64)); // [RULE2]
		end
		else if (state_r == ST_EXEC && cmd_r.op == ulcdu_pkg::OP_LONG_WRITE_REGISTER)
		begin
			status_r <= long_status(wr_val, cmd_r.arg0[7]); // [RULE12]
		end
		else if (state_r == ST_DIV_WB)
		begin
			status_r <= long_status(quo_final, div_w64_r); // [RULE10] [RULE11]
		end
	end

	// ----------------------------------------
	// host-facing outputs
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			peek_r <= 64'h0;
		end
		else
		begin
			peek_r <= read_reg(peek_reg_in);
		end
	end

	assign peek_data_out = peek_r;
	assign status_out = status_r; // [RULE7]
	assign byte_ready_out = (state_r == ST_OPCODE) || (state_r == ST_ARGS);
	assign busy_out = !(state_r == ST_OPCODE);

endmodule

//--- tb/ulcdu_props.sv
// assertions on the ports of the unsigned compare and divide unit
`timescale 1ns/1ps
module ulcdu_props
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_data_in,
	input wire logic byte_ready_out,
	input wire logic [7:0] sel_a_in,
	input wire logic [7:0] peek_reg_in,
	input wire logic [63:0] peek_data_out,
	input wire logic [7:0] status_out,
	input wire logic busy_out
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	logic op_tk;
	assign op_tk = byte_valid_in && byte_ready_out && !busy_out;
	AST_RST_STATUS: assert property ($fell(rst_in) |-> status_out == 8'h00)
		else $error("status not clear after reset");
	AST_IDLE_READY: assert property (!busy_out |-> byte_ready_out)
		else $error("idle unit refuses an opcode");
	AST_HIGH_ZERO: assert property (status_out[7:2] == 6'h00)
		else $error("status upper bits set");
	AST_FLAG_EXCL: assert property (!(status_out[1] && status_out[0]))
		else $error("less and equal both set");
	AST_STAT_CAUSE: assert property ($changed(status_out) |-> $past(busy_out))
		else $error("status changed with no instruction");
	AST_ZERO_CMP: assert property (op_tk && byte_data_in == ulcdu_pkg::OP_UCMP_ZERO
		|=> !byte_ready_out ##1 (byte_ready_out && !busy_out))
		else $error("register zero compare timing wrong");
	AST_DIV_HOLD: assert property (op_tk && byte_data_in == ulcdu_pkg::OP_UDIV_ZERO
		|=> (busy_out && !byte_ready_out)[*8])
		else $error("divide accepted bytes early");
	AST_DIV_END: assert property (op_tk && byte_data_in == ulcdu_pkg::OP_UDIV_ZERO
		|-> ##[60:70] !busy_out)
		else $error("divide did not finish");
	cover property (op_tk && byte_data_in == ulcdu_pkg::OP_UCMP_TWO);
	cover property (op_tk && byte_data_in == ulcdu_pkg::OP_LONG_WRITE_REGISTER);
	cover property ($fell(busy_out) && status_out[1]);
endmodule

bind ulcdu_unit ulcdu_props u_ulcdu_props(.clk_in(clk_in), .rst_in(rst_in),
	.byte_valid_in(byte_valid_in), .byte_data_in(byte_data_in),
	.byte_ready_out(byte_ready_out), .sel_a_in(sel_a_in), .peek_reg_in(peek_reg_in),
	.peek_data_out(peek_data_out), .status_out(status_out), .busy_out(busy_out));

//--- tb/ulcdu_host.sv
// host model that feeds instruction bytes to the unit
`timescale 1ns/1ps
module ulcdu_host
(
	input wire logic clk_in,
	input wire logic ready_in,
	output logic valid_out,
	output logic [7:0] data_out
);
	// ----------------------------------------
	// byte sender
	// ----------------------------------------
	initial
	begin
		valid_out = 1'b0;
		data_out = 8'h00;
	end
	// idle gap cycles model a slow host; data toggles once per gap cycle and once on release
	task automatic send(input logic [7:0] b, input int gap);
		repeat (gap)
		begin
			@(negedge clk_in);
			valid_out = 1'b0;
			data_out = ~data_out;
		end
		@(negedge clk_in);
		valid_out = 1'b1;
		data_out = b;
		while (!ready_in) @(negedge clk_in);
		@(posedge clk_in);
	endtask
	task automatic release_bus();
		@(negedge clk_in);
		valid_out = 1'b0;
		data_out = ~data_out;
	endtask
endmodule

//--- tb/ulcdu_unit_tb.sv
// self-checking testbench for the unsigned compare and divide unit
`timescale 1ns/1ps
module ulcdu_unit_tb;
	logic clk_in;
	logic rst_in;
	logic byte_valid_in;
	logic [7:0] byte_data_in;
	logic byte_ready_out;
	logic [7:0] sel_a_in;
	logic [7:0] peek_reg_in;
	logic [63:0] peek_data_out;
	logic [7:0] status_out;
	logic busy_out;
	int err_total;
	int cmp_count;
	// ----------------------------------------
	// clock, instances and helpers
	// ----------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	ulcdu_unit u_ulcdu_unit(.clk_in(clk_in), .rst_in(rst_in), .byte_valid_in(byte_valid_in),
		.byte_data_in(byte_data_in), .byte_ready_out(byte_ready_out), .sel_a_in(sel_a_in),
		.peek_reg_in(peek_reg_in), .peek_data_out(peek_data_out), .status_out(status_out),
		.busy_out(busy_out));
	ulcdu_host u_ulcdu_host(.clk_in(clk_in), .ready_in(byte_ready_out),
		.valid_out(byte_valid_in), .data_out(byte_data_in));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] q[$], input logic [7:0] st);
		int n;
		foreach (q[i]) u_ulcdu_host.send(q[i], i % 2);
		u_ulcdu_host.release_bus();
		n = 0;
		while (busy_out && n < 100)
		begin
			@(negedge clk_in);
			n++;
		end
		chk({63'h0, busy_out}, 64'h0);
		chk({56'h0, status_out}, {56'h0, st});
	endtask
	task automatic wr(input logic [7:0] r, input logic [31:0] v, input logic [7:0] st);
		cmd('{ulcdu_pkg::OP_LONG_WRITE_REGISTER, r, v[31:24], v[23:16], v[15:8], v[7:0]}, st);
	endtask
	task automatic peek(input logic [7:0] r, input logic [63:0] exp);
		@(negedge clk_in);
		peek_reg_in = r;
		repeat (2) @(negedge clk_in);
		chk(peek_data_out, exp);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sc_write();
		wr(8'h03, 32'h80000001, 8'h02);
		peek(8'h03, 64'hFFFFFFFF80000001);
		wr(8'h81, 32'h80000001, 8'h02);
		peek(8'h81, 64'hFFFFFFFF80000001);
		wr(8'h05, 32'h80000001, 8'h02);
		wr(8'h06, 32'h00000005, 8'h00);
		wr(8'h00, 32'hFFFFFFFF, 8'h02);
		wr(8'h80, 32'h00000000, 8'h01);
		wr(8'h04, 32'h00000000, 8'h01);
	endtask
	task automatic sc_cmp();
		sel_a_in = 8'h03;
		cmd('{ulcdu_pkg::OP_UCMP_REG, 8'h05}, 8'h01);
		cmd('{ulcdu_pkg::OP_UCMP_REG, 8'h06}, 8'h00);
		cmd('{ulcdu_pkg::OP_UCMP_IMM, 8'hFF}, 8'h00);
		peek(8'h03, 64'hFFFFFFFF80000001);
		sel_a_in = 8'h04;
		cmd('{ulcdu_pkg::OP_UCMP_IMM, 8'h01}, 8'h02);
		cmd('{ulcdu_pkg::OP_UCMP_IMM, 8'h00}, 8'h01);
		cmd('{ulcdu_pkg::OP_UCMP_ZERO}, 8'h02);
		sel_a_in = 8'h81;
		cmd('{ulcdu_pkg::OP_UCMP_ZERO}, 8'h00);
		cmd('{ulcdu_pkg::OP_UCMP_REG, 8'h03}, 8'h01);
		cmd('{ulcdu_pkg::OP_UCMP_TWO, 8'h03, 8'h06}, 8'h00);
		cmd('{ulcdu_pkg::OP_UCMP_TWO, 8'h06, 8'h03}, 8'h02);
		cmd('{8'h00}, 8'h02);
		cmd('{ulcdu_pkg::OP_UCMP_TWO, 8'h03, 8'h03}, 8'h01);
	endtask
	task automatic sc_div();
		sel_a_in = 8'h07;
		wr(8'h07, 32'd100, 8'h00);
		wr(8'h08, 32'd7, 8'h00);
		cmd('{ulcdu_pkg::OP_UDIV_REG, 8'h08}, 8'h00);
		peek(8'h07, 64'd14);
		peek(8'h00, 64'd2);
		cmd('{ulcdu_pkg::OP_UDIV_IMM, 8'h00}, 8'h02);
		peek(8'h07, 64'hFFFFFFFFFFFFFFFF);
		peek(8'h00, 64'd14);
		sel_a_in = 8'h82;
		wr(8'h82, 32'd100, 8'h00);
		wr(8'h80, 32'd8, 8'h00);
		cmd('{ulcdu_pkg::OP_UDIV_ZERO}, 8'h00);
		peek(8'h82, 64'd12);
		peek(8'h80, 64'd4);
		cmd('{ulcdu_pkg::OP_UDIV_IMM, 8'h03}, 8'h00);
		peek(8'h82, 64'd4);
		peek(8'h80, 64'd0);
		cmd('{ulcdu_pkg::OP_UDIV_IMM, 8'h00}, 8'h02);
		peek(8'h82, 64'hFFFFFFFFFFFFFFFF);
	endtask
	initial
	begin
		err_total = 0;
		cmp_count = 0;
		rst_in = 1'b1;
		sel_a_in = 8'h00;
		peek_reg_in = 8'h00;
		repeat (5) @(negedge clk_in);
		rst_in = 1'b0;
		chk({56'h0, status_out}, 64'h0);
		sc_write();
		sc_cmp();
		sc_div();
		print_verdict();
	end
	initial
	begin
		#250000;
		err_total++;
		print_verdict();
	end
endmodule
